// *** rtl/baud_rate_generator.v ***
// Purpose: baud rate generator with plain register port
// Assumes: 10 MHz mclk, read data one cycle after the read strobe
// Notes: outputs are enables, never derived clocks
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "baud_gen_map.vh"
module baud_rate_generator (
  input wire mclk,
  input wire nrst,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ext_clk,
  output reg sample_tick,
  output reg bit_tick,
  output reg gen_active
);
  reg [31:0] mode_config_register;
  reg [31:0] baud_generator_register;
  reg [15:0] div_cnt;
  reg [2:0] frac_acc;
  reg frac_extra;
  reg [4:0] over_cnt;
  reg next_sample;
  reg next_bit;
  reg src_tick;
  reg [15:0] next_div_cnt;
  reg [2:0] next_frac_acc;
  reg next_frac_extra;
  reg [4:0] next_over_cnt;
  wire pre_tick;
  wire ext_level;
  wire ext_rise;
  reg [23:0] bit_gap;
  reg [23:0] bit_period;
  reg bit_armed;
  reg [23:0] sample_gap;
  reg [23:0] sample_period;
  reg sample_armed;
  reg [15:0] bit_count;
  reg [15:0] sample_count;
  reg restart;
  reg [23:0] next_bit_gap;
  reg [23:0] next_bit_period;
  reg next_bit_armed;
  reg [23:0] next_sample_gap;
  reg [23:0] next_sample_period;
  reg next_sample_armed;
  reg [23:0] pin_gap;
  reg [23:0] pin_period;
  reg pin_armed;
  reg pin_fast;
  wire cfg_write;
  wire div_done;

  wire [1:0] clock_source_select = mode_config_register[`MODE_SRC_MSB:`MODE_SRC_LSB];
  wire sync_mode = mode_config_register[`MODE_SYNC_BIT];
  wire over = mode_config_register[`MODE_OVER_BIT];
  wire normal_mode = mode_config_register[`MODE_NORMAL_BIT];
  wire [15:0] clock_divisor = baud_generator_register[`BAUD_CD_MSB:`BAUD_CD_LSB];
  wire [2:0] fractional_part = baud_generator_register[`BAUD_FP_MSB:`BAUD_FP_LSB];

  // Fraction only in asynchronous normal mode with a nonzero field
  wire frac_on = (fractional_part != 3'h0) && normal_mode && !sync_mode;
  wire ext_direct = sync_mode && (clock_source_select == `SRC_EXT);

  // Width of the oversampling stage chosen from the over bit
  function [4:0] over_ratio;
    input ov;
    begin
      over_ratio = ov ? `OVER8 : `OVER16;
    end
  endfunction

  // Saturating step for the meters; a stalled generator must not wrap to small values
  function [23:0] sat_inc;
    input [23:0] v;
    begin
      if (v == `METER_MAX) begin
        sat_inc = v;
      end else begin
        sat_inc = v + 24'h000001;
      end
    end
  endfunction

  // One bit wider, so a full divisor plus the stretch cannot wrap
  function period_end;
    input [15:0] cnt;
    input [15:0] limit;
    input extra;
    begin
      period_end = ({1'b0, cnt} + 17'h00001) >= ({1'b0, limit} + {16'h0000, extra});
    end
  endfunction

  // Writes that change the rate
  function cfg_addr;
    input [`ADDR_W-1:0] a;
    begin
      cfg_addr = (a == `ADDR_MODE_CONFIG) || (a == `ADDR_BAUD_GEN);
    end
  endfunction

  assign cfg_write = wr && cfg_addr(addr);
  assign div_done = period_end(div_cnt, clock_divisor, frac_extra);

  fixed_prescaler u_pre (
    .mclk(mclk),
    .nrst(nrst),
    .tick(pre_tick)
  );

  // External pin assumed well-behaved, so one synchronised rise is one source edge
  pin_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(ext_clk),
    .level(ext_level),
    .rise(ext_rise)
  );

  always @* begin
    if (clock_source_select == `SRC_PCLK) begin
      src_tick = 1'b1;
    end else if (clock_source_select == `SRC_PCLK_DIV) begin
      src_tick = pre_tick;
    end else begin
      src_tick = ext_rise;
    end
  end

  always @* begin
    next_div_cnt = div_cnt;
    next_frac_acc = frac_acc;
    next_frac_extra = frac_extra;
    next_over_cnt = over_cnt;
    next_sample = 1'b0;
    next_bit = 1'b0;
    if (restart) begin
      // A new setting starts a clean period rather than finish one timed by the old
      next_div_cnt = 16'h0000;
      next_over_cnt = 5'h00;
      next_frac_acc = 3'h0;
      next_frac_extra = 1'b0;
    end else if (ext_direct) begin
      next_bit = ext_rise;
      next_sample = ext_rise;
      next_div_cnt = 16'h0000;
    end else if (clock_divisor == 16'h0000) begin
      next_div_cnt = 16'h0000;
      next_over_cnt = 5'h00;
    end else if (src_tick) begin
      // Divisor one: count advances only in a stretched period, otherwise every source tick passes
      if (div_done) begin
        next_div_cnt = 16'h0000;
        next_sample = 1'b1;
        if (frac_on) begin
          // Stretch by one source period in fractional_part of every eight
          {next_frac_extra, next_frac_acc} = {1'b0, frac_acc} + {1'b0, fractional_part};
        end else begin
          next_frac_extra = 1'b0;
          next_frac_acc = 3'h0;
        end
        if (sync_mode) begin
          next_bit = 1'b1;
          next_over_cnt = 5'h00;
        end else if (over_cnt + 5'h01 >= over_ratio(over)) begin
          next_over_cnt = 5'h00;
          next_bit = 1'b1;
        end else begin
          next_over_cnt = over_cnt + 5'h01;
        end
      end else begin
        next_div_cnt = div_cnt + 16'h0001;
      end
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 16'h0000;
      frac_acc <= 3'h0;
      frac_extra <= 1'b0;
      over_cnt <= 5'h00;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
      gen_active <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      frac_acc <= next_frac_acc;
      frac_extra <= next_frac_extra;
      over_cnt <= next_over_cnt;
      sample_tick <= next_sample;
      bit_tick <= next_bit;
      gen_active <= ext_direct || (clock_divisor != 16'h0000);
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_config_register <= `MODE_RESET;
      baud_generator_register <= `BAUD_RESET;
    end else if (wr) begin
      if (addr == `ADDR_MODE_CONFIG) begin
        mode_config_register <= {27'h0000000, wdata[4:0]};
      end else if (addr == `ADDR_BAUD_GEN) begin
        baud_generator_register <= {13'h0000, wdata[18:0]};
      end
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr == `ADDR_MODE_CONFIG) begin
        rdata <= mode_config_register;
      end else if (addr == `ADDR_BAUD_GEN) begin
        rdata <= baud_generator_register;
      end else if (addr == `ADDR_STATUS) begin
        rdata <= {23'h000000, pin_fast, ext_level, frac_on, gen_active, over_cnt};
      end else if (addr == `ADDR_BIT_PERIOD) begin
        rdata <= {8'h00, bit_period};
      end else if (addr == `ADDR_SAMPLE_PERIOD) begin
        rdata <= {8'h00, sample_period};
      end else if (addr == `ADDR_TICK_COUNT) begin
        rdata <= {bit_count, sample_count};
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // Meters time the gaps between launched ticks, so software can check the rate
  always @* begin
    next_bit_gap = sat_inc(bit_gap);
    next_bit_period = bit_period;
    next_bit_armed = bit_armed;
    next_sample_gap = sat_inc(sample_gap);
    next_sample_period = sample_period;
    next_sample_armed = sample_armed;
    if (restart) begin
      // The gap that spans a new setting belongs to neither rate
      next_bit_gap = 24'h000000;
      next_bit_armed = 1'b0;
      next_sample_gap = 24'h000000;
      next_sample_armed = 1'b0;
    end else begin
      if (bit_tick) begin
        next_bit_gap = 24'h000000;
        next_bit_armed = 1'b1;
        if (bit_armed) begin
          next_bit_period = sat_inc(bit_gap);
        end
      end
      if (sample_tick) begin
        next_sample_gap = 24'h000000;
        next_sample_armed = 1'b1;
        if (sample_armed) begin
          next_sample_period = sat_inc(sample_gap);
        end
      end
    end
  end

  // Free-running tick counts; they wrap, software takes differences
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_count <= 16'h0000;
      sample_count <= 16'h0000;
    end else begin
      if (bit_tick) begin
        bit_count <= bit_count + 16'h0001;
      end
      if (sample_tick) begin
        sample_count <= sample_count + 16'h0001;
      end
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      restart <= 1'b0;
      bit_gap <= 24'h000000;
      bit_period <= 24'h000000;
      bit_armed <= 1'b0;
      sample_gap <= 24'h000000;
      sample_period <= 24'h000000;
      sample_armed <= 1'b0;
    end else begin
      restart <= cfg_write;
      bit_gap <= next_bit_gap;
      bit_period <= next_bit_period;
      bit_armed <= next_bit_armed;
      sample_gap <= next_sample_gap;
      sample_period <= next_sample_period;
      sample_armed <= next_sample_armed;
    end
  end

  // Pin rise spacing shows whether the far clock keeps its shortest legal period
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_gap <= 24'h000000;
      pin_period <= 24'h000000;
      pin_armed <= 1'b0;
      pin_fast <= 1'b0;
    end else if (ext_rise) begin
      pin_gap <= 24'h000000;
      pin_period <= sat_inc(pin_gap);
      pin_armed <= 1'b1;
      // Sticky until a setting is written; a fast rise in the same cycle still sets it
      if (pin_armed && sat_inc(pin_gap) < `PIN_MIN_GAP) begin
        pin_fast <= 1'b1;
      end else if (cfg_write) begin
        pin_fast <= 1'b0;
      end
    end else begin
      pin_gap <= sat_inc(pin_gap);
      if (cfg_write) begin
        pin_fast <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/fixed_prescaler.v ***
// Purpose: fixed divide of the peripheral clock, as a one-cycle enable
// Assumes: ratio taken from the map header
// Notes: free running from reset
`timescale 1ns/1ps
`include "baud_gen_map.vh"
module fixed_prescaler (
  input wire mclk,
  input wire nrst,
  output reg tick
);
  reg [3:0] cnt;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      tick <= 1'b0;
    end else begin
      if (cnt == `PRESCALE_DIV - 4'h1) begin
        cnt <= 4'h0;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
        tick <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/pin_sync.v ***
// Purpose: three flip-flop synchroniser with agreement check for the clock pin
// Assumes: pin changes slower than one mclk period
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync (
  input wire mclk,
  input wire nrst,
  input wire pin,
  output reg level,
  output reg rise
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      rise <= 1'b0;
      // A change counts only once the second and third stages agree
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise <= s3;
      end
    end
  end
endmodule

// *** shared/baud_gen_map.vh ***
// Purpose: constants of the serial baud rate generator
// Assumes: register word offsets on the plain register port, 10 MHz mclk
// Notes: the header holds definitions only
`ifndef BAUD_GEN_MAP_VH
`define BAUD_GEN_MAP_VH

`define ADDR_W 4
`define ADDR_MODE_CONFIG 4'h0
`define ADDR_BAUD_GEN 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_BIT_PERIOD 4'h3
`define ADDR_SAMPLE_PERIOD 4'h4
`define ADDR_TICK_COUNT 4'h5

`define MODE_SRC_LSB 0
`define MODE_SRC_MSB 1
`define MODE_SYNC_BIT 2
`define MODE_OVER_BIT 3
`define MODE_NORMAL_BIT 4
`define MODE_RESET 32'h00000010

`define BAUD_CD_LSB 0
`define BAUD_CD_MSB 15
`define BAUD_FP_LSB 16
`define BAUD_FP_MSB 18
`define BAUD_RESET 32'h00000000

`define SRC_PCLK 2'h0
`define SRC_PCLK_DIV 2'h1
`define SRC_EXT_ALT 2'h2
`define SRC_EXT 2'h3

`define PRESCALE_DIV 4'h8
`define OVER16 5'h10
`define OVER8 5'h08
`define FRAC_STEPS 4'h8
`define METER_MAX 24'hFFFFFF
`define PIN_MIN_GAP 24'h000004

`endif

// *** sim/baud_gen_monitor.sv ***
// Purpose: port checker for the baud generator
// Assumes: configuration changes only by port writes
// Notes: register shadows tell every check but a_bit_sample the setting
`timescale 1ns/1ps
`include "baud_gen_map.vh"
module baud_gen_monitor (
  input wire mclk,
  input wire nrst,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire sample_tick,
  input wire bit_tick,
  input wire gen_active
);
  logic [4:0] mode;
  logic [18:0] baud;
  logic [5:0] q;
  // Checks wait out the settling after a write
  wire calm = &q;
  wire one = calm && baud == 19'h1;
  wire ext = mode[2] && mode[1:0] == 2'h3;
  always @(posedge mclk or negedge nrst)
    if (!nrst) {mode, baud, q} <= {5'h10, 19'h0, 6'h0};
    else if (wr) {mode, baud, q} <= {addr == `ADDR_MODE_CONFIG ? wdata[4:0] : mode,
      addr == `ADDR_BAUD_GEN ? wdata[18:0] : baud, 6'h0};
    else if (!calm) q <= q + 6'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_baud_read: assert property (rd && addr == `ADDR_BAUD_GEN |=> rdata == {13'h0, baud})
    else $error("baud readback");
  a_bit_sample: assert property (bit_tick |-> sample_tick)
    else $error("bit without sample");
  a_cd_zero: assert property (calm && baud[15:0] == 16'h0 && !ext |-> !sample_tick && !gen_active)
    else $error("ticks at zero divisor");
  a_cd_one: assert property (one && mode[1:0] == 2'h0 |-> sample_tick)
    else $error("divisor one not bypassed");
  a_prescale_gap: assert property (@(posedge mclk) disable iff (!nrst || wr)
    one && mode[1:0] == 2'h1 && sample_tick |=> !sample_tick [*7] ##1 sample_tick)
    else $error("prescale gap");
  a_async_bit: assert property (@(posedge mclk) disable iff (!nrst || wr)
    one && mode[3:0] == 4'h8 && bit_tick |=> !bit_tick [*7] ##1 bit_tick)
    else $error("async bit gap");
  a_sync_pair: assert property (calm && mode[2] |-> bit_tick == sample_tick)
    else $error("sync bit differs");
  a_ext_direct: assert property (calm && ext |-> gen_active)
    else $error("pin clock idle");
  c_frac: cover property (mode[4] && baud[18:16] != 3'h0 && bit_tick);
  c_ext: cover property (ext && bit_tick);
  c_pre: cover property (mode[1:0] == 2'h1 && bit_tick);
endmodule

// *** sim/serial_side_model.sv ***
// Purpose: clock source on the serial clock pin, the far party
// Assumes: half period well above one mclk period
// Notes: the pin stands still while run is low
`timescale 1ns/1ps
module serial_side_model #(
  parameter int HALF_NS = 300
) (
  input wire run,
  output logic pin
);
  // Start offset keeps pin edges off the mclk edges
  initial begin
    pin = 1'b0;
    #25;
    forever begin
      #(HALF_NS);
      if (run) pin = !pin;
    end
  end
endmodule

// *** sim/tb.sv ***
// Purpose: self-checking bench for the baud generator
// Assumes: ticks are one-cycle pulses seen at the falling edge
// Notes: corner settings run ahead of seeded random ones
`timescale 1ns/1ps
`include "baud_gen_map.vh"
module tb;
  localparam int HALF_NS = 300;
  logic mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
  logic [`ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, md, bd;
  logic sample_tick, bit_tick, gen_active, ext_clk;
  int n_errors = 0, checks = 0, k;
  logic [31:0] cases [12] = '{32'h18, 32'h1, 32'h4, 32'h100, 32'h11, 32'h50003,
    32'h0, 32'h30002, 32'h7, 32'h0, 32'hA, 32'h1};
  always #50 mclk = !mclk;
  baud_rate_generator dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_clk(ext_clk), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .gen_active(gen_active));
  serial_side_model #(.HALF_NS(HALF_NS)) far_u (.run(run), .pin(ext_clk));
  function automatic int exp_bit(input logic [31:0] m, input logic [31:0] b);
    int pre, cd, f;
    pre = m[1:0] == 2'h1 ? 8 : m[1] ? HALF_NS / 50 : 1;
    cd = m[2] && m[1:0] == 2'h3 ? 1 : int'(b[15:0]);
    f = m[4] ? int'(b[18:16]) : 0;
    return m[2] ? pre * cd : pre * (2 - int'(m[3])) * (8 * cd + f);
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    cmp(rdata, e);
    @(posedge mclk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(62085));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rreg(`ADDR_MODE_CONFIG, `MODE_RESET);
    rreg(`ADDR_BAUD_GEN, `BAUD_RESET);
    wreg(4'hF, 32'hFFFFFFFF);
    rreg(4'hF, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      md = i < 6 ? cases[2 * i] : $urandom & 32'h1D;
      bd = i < 6 ? cases[2 * i + 1] : $urandom & 32'hFFFF0000 | $urandom_range(2, 1);
      run <= md[1];
      wreg(`ADDR_MODE_CONFIG, md);
      wreg(`ADDR_BAUD_GEN, bd);
      rreg(`ADDR_BAUD_GEN, bd & 32'h7FFFF);
      // The first period after a change is not timed
      repeat (2) begin
        k = 0;
        do begin
          @(negedge mclk);
          k++;
        end while (!bit_tick && k < 4000);
      end
      cmp(k, exp_bit(md, bd));
      @(posedge mclk);
      rreg(`ADDR_BIT_PERIOD, exp_bit(md, bd));
      $display("test case %0d done", i);
    end
    run <= 1'b0;
    wreg(`ADDR_BAUD_GEN, 32'h0);
    // Ticks already launched may still drain
    repeat (3) @(posedge mclk);
    k = 0;
    repeat (100) begin
      @(negedge mclk);
      k += int'(sample_tick | bit_tick | gen_active);
    end
    cmp(k, 0);
    $display("test zero divisor done");
    results();
  end
  initial begin
    // Well above the longest expected run, still under the cycle budget
    #(95000 * 100);
    n_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    results();
  end
endmodule
bind baud_rate_generator baud_gen_monitor mon_u (.mclk(mclk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_tick(sample_tick),
  .bit_tick(bit_tick), .gen_active(gen_active));
